// File: vmoc_pkg.sv
// Package: constants and types of the valve motor open/close output block
package vmoc_pkg;

    // ---------------------------------------------------------------
    // Clock and time base
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int MS_PERIOD_PS = 1000000000;
    localparam int MS_CYCLES_DEF = MS_PERIOD_PS / CLK_PERIOD_PS;
    localparam int MS_PER_S = 1000;
    localparam int KEY_HOLD_S = 5;
    localparam int KEY_HOLD_MS = KEY_HOLD_S * MS_PER_S;
    localparam int IDLE_S = 60;
    localparam int IDLE_MS = IDLE_S * MS_PER_S;
    localparam int MOTOR_MIN_S = 5;
    localparam int MOTOR_MIN_MS = MOTOR_MIN_S * MS_PER_S;
    localparam int CAL_SETTLE_MS = 1000;

    // ---------------------------------------------------------------
    // Settings: ranges and values after reset (outputs in 0.1 %)
    // ---------------------------------------------------------------
    localparam logic [9:0] FULL_SCALE = 10'h3e8;
    localparam logic [6:0] NZ_DEF = 7'h14;
    localparam logic [5:0] GAP_DEF = 6'h0a;
    localparam logic [9:0] MOTOR_DEF = 10'h00a;
    localparam logic [9:0] MOTOR_MIN = 10'h005;
    localparam logic [9:0] MOTOR_MAX = 10'h3e8;
    localparam logic [10:0] LIM_DEF = 11'h5dc;
    localparam logic [10:0] LIM_OFF = 11'h000;

    // ---------------------------------------------------------------
    // Codes
    // ---------------------------------------------------------------
    localparam logic BRK_STOP_ACT = 1'b0;
    localparam logic BRK_CONTINUE = 1'b1;
    localparam logic [1:0] STOP_BOTH_OFF = 2'h0;
    localparam logic [1:0] STOP_CLOSE_ON = 2'h1;
    localparam logic [1:0] STOP_OPEN_ON = 2'h2;
    localparam logic [1:0] CAL_END = 2'h0;
    localparam logic [1:0] CAL_OPEN = 2'h1;
    localparam logic [1:0] CAL_CLOSE = 2'h2;
    localparam logic [1:0] ST_ALL = 2'h0;
    localparam logic [1:0] ST_POWER_RUN = 2'h1;
    localparam logic [1:0] ST_TARGET_ONLY = 2'h2;

    typedef enum logic [1:0] {CS_IDLE, CS_OPEN, CS_CLOSE} vmoc_cal_t;

endpackage

// File: vmoc_aux_if.sv
// Interface: signals shared by the core, its key timer and position scaler
`timescale 1ns/1ps
interface vmoc_aux_if;
    logic ms_tick;
    logic hold_done;
    logic idle_done;
    logic shift_key;
    logic any_key;
    logic calibrating;
    logic [11:0] fb_raw;
    logic [11:0] cal_zero;
    logic [11:0] cal_open;
    logic [9:0] valve_pos;

    modport timer (output ms_tick, output hold_done, output idle_done,
        input shift_key, input any_key, input calibrating);
    modport scale (input fb_raw, input cal_zero, input cal_open,
        output valve_pos);
endinterface

// File: vmoc_key_timer.sv
// Module: millisecond time base, shift-key hold and key idle timers
`timescale 1ns/1ps
module vmoc_key_timer
    import vmoc_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    vmoc_aux_if.timer aux
);
    typedef struct packed {
        logic [17:0] pre;
        logic tick;
        logic [12:0] hold;
        logic hold_done;
        logic [15:0] idle;
        logic idle_done;
    } vmoc_tmr_t;

    vmoc_tmr_t s;
    vmoc_tmr_t next_s;

    // Hold counter restarts while calibrating, so a finished run needs
    // a fresh five second hold before another one can begin
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        next_s.idle_done = 1'b0;
        if (s.pre >= 18'(MS_CYCLES - 1)) begin
            next_s.pre = 18'h0;
            next_s.tick = 1'b1;
        end else begin
            next_s.pre = s.pre + 18'h1;
        end
        if (!aux.shift_key || aux.calibrating) begin
            next_s.hold = 13'h0;
            next_s.hold_done = 1'b0;
        end else if (s.tick && !s.hold_done) begin
            next_s.hold = s.hold + 13'h1;
            next_s.hold_done = (s.hold + 13'h1) >= 13'(KEY_HOLD_MS);
        end
        if (aux.any_key || aux.calibrating) begin
            next_s.idle = 16'h0;
        end else if (s.tick && s.idle < 16'(IDLE_MS)) begin
            next_s.idle = s.idle + 16'h1;
            next_s.idle_done = (s.idle + 16'h1) == 16'(IDLE_MS);
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign aux.ms_tick = s.tick;
    assign aux.hold_done = s.hold_done;
    assign aux.idle_done = s.idle_done;

    hold_min_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(s.hold_done) |-> s.hold == 13'(KEY_HOLD_MS))
        else $error("shift hold ended at wrong count");
endmodule

// File: vmoc_pos_scale.sv
// Module: maps raw feedback onto the calibrated 0 to 100 % valve span
`timescale 1ns/1ps
module vmoc_pos_scale
    import vmoc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    vmoc_aux_if.scale aux
);
    typedef struct packed {
        logic [9:0] pos;
    } vmoc_scl_t;

    vmoc_scl_t s;
    vmoc_scl_t next_s;
    logic [11:0] span;
    logic [11:0] rel;
    logic [21:0] quo;

    // Readings beyond either calibrated end clamp to 0 or 100 %
    assign span = aux.cal_open - aux.cal_zero;
    assign rel = aux.fb_raw - aux.cal_zero;
    assign quo = (22'(rel) * 22'(FULL_SCALE)) / 22'(span);

    always_comb begin
        next_s = s;
        if (aux.cal_open <= aux.cal_zero || aux.fb_raw <= aux.cal_zero) begin
            next_s.pos = 10'h0;
        end else if (aux.fb_raw >= aux.cal_open) begin
            next_s.pos = FULL_SCALE;
        end else begin
            next_s.pos = quo[9:0];
        end
    end

    // Registered position
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign aux.valve_pos = s.pos;

    span_top_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (aux.cal_open > aux.cal_zero && aux.fb_raw >= aux.cal_open)
        |=> s.pos == FULL_SCALE)
        else $error("open end does not read full scale");
endmodule

// File: vmoc_core.sv
// Module: open/close output logic for a position-proportioning valve motor
`timescale 1ns/1ps
module vmoc_core
    import vmoc_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic pos_pid_selected,
    input wire logic run_mode,
    input wire logic [9:0] manipulated_output,
    input wire logic signed [15:0] pid_delta,
    input wire logic [6:0] neutral_zone,
    input wire logic [5:0] diff_gap,
    input wire logic [10:0] limiter_setting,
    input wire logic [9:0] motor_time_in,
    input wire logic motor_time_wr,
    input wire logic fb_fitted,
    input wire logic fb_break,
    input wire logic [11:0] valve_position_feedback,
    input wire logic break_action,
    input wire logic [1:0] stop_action,
    input wire logic sat_action,
    input wire logic [9:0] out_limit_low,
    input wire logic [9:0] out_limit_high,
    input wire logic shift_key,
    input wire logic any_key,
    input wire logic prep_screen_req,
    input wire logic [1:0] auto_startup_tune_cond,
    input wire logic [15:0] target_setpoint,
    output logic drive_open,
    output logic drive_close,
    output logic [9:0] motor_time,
    output logic [1:0] cal_state,
    output logic at_prep_screen,
    output logic at_monitor_screen,
    output logic [9:0] valve_position,
    output logic auto_startup_tune
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        vmoc_cal_t cal;
        logic open;
        logic close;
        logic dir_open;
        logic blk_open;
        logic blk_close;
        logic [20:0] acc;
        logic [9:0] motor;
        logic [19:0] cal_ms;
        logic [15:0] stable_ms;
        logic [11:0] last_raw;
        logic [11:0] zero;
        logic [11:0] span_end;
        logic prep;
        logic monitor;
        logic por;
        logic run_q;
        logic [15:0] sv_q;
        logic st;
    } vmoc_core_t;

    vmoc_core_t s;
    vmoc_core_t next_s;

    vmoc_aux_if aux ();

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Magnitude of a signed deviation, saturated so -32768 cannot wrap
    function automatic logic [15:0] vmoc_mag(input logic signed [15:0] v);
        if (v == 16'sh8000) begin
            return 16'h7fff;
        end
        return (v < 0) ? 16'(-v) : 16'(v);
    endfunction

    // Stepping a millisecond counter without wrapping
    function automatic logic [19:0] vmoc_inc(input logic [19:0] v);
        return (v == 20'hfffff) ? v : v + 20'h1;
    endfunction

    // ---------------------------------------------------------------
    // Submodules
    // ---------------------------------------------------------------
    assign aux.shift_key = shift_key;
    assign aux.any_key = any_key;
    assign aux.calibrating = (s.cal != CS_IDLE);
    assign aux.fb_raw = valve_position_feedback;
    assign aux.cal_zero = s.zero;
    assign aux.cal_open = s.span_end;

    vmoc_key_timer #(.MS_CYCLES(MS_CYCLES)) vmoc_key_timer_inst (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .aux(aux.timer)
    );

    vmoc_pos_scale vmoc_pos_scale_inst (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .aux(aux.scale)
    );

    // ---------------------------------------------------------------
    // Decision terms
    // ---------------------------------------------------------------
    logic fb_in_use;
    logic stop_apply;
    logic normal_path;
    logic lim_en;
    logic signed [15:0] dev;
    logic [15:0] dev_mag;
    logic [15:0] nz_on;
    logic [15:0] nz_off;
    logic req_open;
    logic req_close;
    logic at_closed;
    logic at_opened;
    logic ctl_open;
    logic ctl_close;
    logic [20:0] limit_ms;
    logic cal_start;

    // Broken feedback with continue code falls back to the open-loop path
    assign fb_in_use = fb_fitted && !fb_break;
    assign stop_apply = (!fb_fitted && !run_mode)
        || (fb_fitted && fb_break && break_action == BRK_STOP_ACT);
    assign normal_path = pos_pid_selected && s.cal == CS_IDLE
        && !stop_apply && run_mode;
    assign lim_en = !fb_in_use && limiter_setting != LIM_OFF;
    assign limit_ms = 21'(s.motor) * 21'(limiter_setting);

    // Closed loop compares target with position, open loop uses the step
    assign dev = fb_in_use
        ? 16'(signed'({6'h0, manipulated_output})
            - signed'({6'h0, aux.valve_pos}))
        : pid_delta;
    assign dev_mag = vmoc_mag(dev);
    assign nz_on = {9'h0, neutral_zone};
    assign nz_off = (neutral_zone > 7'(diff_gap))
        ? {9'h0, neutral_zone - 7'(diff_gap)} : 16'h0;

    // An active side is kept until the deviation falls below zone less gap
    assign req_open = !dev[15]
        && (dev_mag > (s.open ? nz_off : nz_on));
    assign req_close = dev[15]
        && (dev_mag > (s.close ? nz_off : nz_on));

    // Valve ends only known with live feedback; limiter values move them
    assign at_closed = fb_in_use && aux.valve_pos <= out_limit_low;
    assign at_opened = fb_in_use && aux.valve_pos >= out_limit_high;

    always_comb begin
        if (at_opened) begin
            ctl_open = sat_action && s.open;
        end else begin
            ctl_open = req_open && !(lim_en && s.blk_open);
        end
        if (at_closed) begin
            ctl_close = sat_action && s.close;
        end else begin
            ctl_close = req_close && !(lim_en && s.blk_close);
        end
    end

    assign cal_start = pos_pid_selected && fb_fitted && s.prep
        && aux.hold_done && s.cal == CS_IDLE;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        logic want_open;
        logic want_close;
        logic [19:0] travel;
        want_open = 1'b0;
        want_close = 1'b0;
        travel = 20'h0;
        next_s = s;
        next_s.st = 1'b0;

        // Startup tuning start condition
        next_s.por = 1'b0;
        next_s.run_q = run_mode;
        next_s.sv_q = target_setpoint;
        if (s.por && auto_startup_tune_cond != ST_TARGET_ONLY) begin
            next_s.st = 1'b1;
        end
        if (run_mode && !s.run_q
            && auto_startup_tune_cond != ST_TARGET_ONLY) begin
            next_s.st = 1'b1;
        end
        if (!s.por && target_setpoint != s.sv_q
            && auto_startup_tune_cond != ST_POWER_RUN) begin
            next_s.st = 1'b1;
        end

        // Motor time setting, out-of-range writes are ignored
        if (motor_time_wr && motor_time_in >= MOTOR_MIN
            && motor_time_in <= MOTOR_MAX) begin
            next_s.motor = motor_time_in;
        end

        // Screen selection; idle return is suppressed while calibrating
        if (s.cal == CS_IDLE) begin
            if (prep_screen_req) begin
                next_s.prep = 1'b1;
                next_s.monitor = 1'b0;
            end else if (aux.idle_done) begin
                next_s.prep = 1'b0;
                next_s.monitor = 1'b1;
            end
        end

        // Calibration: run open until the reading settles, then close
        case (s.cal)
            CS_IDLE: begin
                if (cal_start) begin
                    next_s.cal = CS_OPEN;
                    next_s.cal_ms = 20'h0;
                    next_s.stable_ms = 16'h0;
                    next_s.last_raw = valve_position_feedback;
                end
            end
            CS_OPEN: begin
                if (aux.ms_tick) begin
                    next_s.cal_ms = vmoc_inc(s.cal_ms);
                    next_s.last_raw = valve_position_feedback;
                    next_s.stable_ms =
                        (valve_position_feedback == s.last_raw)
                        ? s.stable_ms + 16'h1 : 16'h0;
                    if (s.stable_ms >= 16'(CAL_SETTLE_MS)) begin
                        travel = s.cal_ms - 20'(CAL_SETTLE_MS);
                        next_s.span_end = valve_position_feedback;
                        // Short runs suggest a fault, so keep old value
                        if (travel >= 20'(MOTOR_MIN_MS)) begin
                            next_s.motor =
                                (travel / 20'(MS_PER_S) > 20'(MOTOR_MAX))
                                ? MOTOR_MAX
                                : 10'(travel / 20'(MS_PER_S));
                        end
                        next_s.cal = CS_CLOSE;
                        next_s.cal_ms = 20'h0;
                        next_s.stable_ms = 16'h0;
                    end
                end
            end
            CS_CLOSE: begin
                if (aux.ms_tick) begin
                    next_s.last_raw = valve_position_feedback;
                    next_s.stable_ms =
                        (valve_position_feedback == s.last_raw)
                        ? s.stable_ms + 16'h1 : 16'h0;
                    if (s.stable_ms >= 16'(CAL_SETTLE_MS)) begin
                        next_s.zero = valve_position_feedback;
                        next_s.cal = CS_IDLE;
                        next_s.prep = 1'b1;
                        next_s.monitor = 1'b0;
                    end
                end
            end
            default: next_s.cal = CS_IDLE;
        endcase
        if (!pos_pid_selected || !fb_fitted) begin
            next_s.cal = CS_IDLE;
        end

        // Direction selection by priority
        if (!pos_pid_selected) begin
            want_open = 1'b0;
            want_close = 1'b0;
        end else if (s.cal != CS_IDLE) begin
            want_open = (s.cal == CS_OPEN);
            want_close = (s.cal == CS_CLOSE);
        end else if (stop_apply) begin
            want_open = (stop_action == STOP_OPEN_ON);
            want_close = (stop_action == STOP_CLOSE_ON);
        end else if (run_mode) begin
            want_open = ctl_open;
            want_close = ctl_close;
        end

        // A reversal passes through one cycle with both sides off
        next_s.open = want_open && !s.close;
        next_s.close = want_close && !s.open && !want_open;

        // Integrated on-time; a change of side starts a fresh total
        if ((next_s.open && !s.dir_open) || (next_s.close && s.dir_open)) begin
            next_s.dir_open = next_s.open;
            next_s.acc = 21'h0;
            next_s.blk_open = 1'b0;
            next_s.blk_close = 1'b0;
        end else if (lim_en && aux.ms_tick && (s.open || s.close)) begin
            next_s.acc = s.acc + 21'h1;
            if (s.acc + 21'h1 >= limit_ms) begin
                next_s.blk_open = s.open;
                next_s.blk_close = s.close;
            end
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.motor <= MOTOR_DEF;
            s.monitor <= 1'b1;
            s.por <= 1'b1;
            s.span_end <= 12'hfff;
        end else begin
            s <= next_s;
        end
    end

    assign drive_open = s.open;
    assign drive_close = s.close;
    assign motor_time = s.motor;
    // Enum order gives the reported codes, so the flop drives the pin
    assign cal_state = s.cal;
    assign at_prep_screen = s.prep;
    assign at_monitor_screen = s.monitor;
    assign valve_position = aux.valve_pos;
    assign auto_startup_tune = s.st;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    no_overlap_a: assert property (!(drive_open && drive_close))
        else $error("open and close driven together");

    reversal_gap_a: assert property ($rose(drive_open)
        |-> !$past(drive_close))
        else $error("open raised straight after close");

    mode_gate_a: assert property (!pos_pid_selected
        |=> !drive_open && !drive_close)
        else $error("drive outside position PID mode");

    neutral_off_a: assert property ((normal_path && !s.open && !s.close
        && dev_mag <= nz_on) |=> !drive_open && !drive_close)
        else $error("drive started inside neutral zone");

    gap_hold_a: assert property ((normal_path && s.open && !at_opened
        && !dev[15] && dev_mag > nz_off && !(lim_en && s.blk_open))
        |=> drive_open)
        else $error("open side dropped inside the gap");

    limit_block_a: assert property ((normal_path && lim_en && s.blk_open)
        |=> !drive_open)
        else $error("open kept on after limit");

    rev_clear_a: assert property ($rose(drive_close) && $past(s.dir_open)
        |-> s.acc == 21'h0 && !s.blk_close)
        else $error("on-time total kept across reversal");

    sat_stop_a: assert property ((normal_path && !sat_action
        && at_opened) |=> !drive_open)
        else $error("open drive kept at open end");

    stop_open_a: assert property ((pos_pid_selected && s.cal == CS_IDLE
        && fb_fitted && fb_break && break_action == BRK_STOP_ACT
        && stop_action == STOP_OPEN_ON && !s.close)
        |=> drive_open && !drive_close)
        else $error("stop action open not applied");

    cal_code_a: assert property ($rose(cal_state == CAL_OPEN)
        |-> $past(at_prep_screen) ##[1:2] drive_open ##1 drive_open)
        else $error("calibration began without open drive");

    st_run_a: assert property (($rose(run_mode)
        && auto_startup_tune_cond != ST_TARGET_ONLY)
        |=> auto_startup_tune)
        else $error("startup tune missed on run");

    st_cover_c: cover property ($rose(auto_startup_tune));
    cal_done_c: cover property ($fell(cal_state == CAL_CLOSE));
    limit_hit_c: cover property ($rose(s.blk_open));
    sat_hold_c: cover property (sat_action && at_opened && drive_open);
endmodule

// File: vmoc_valve_model.sv
// Model: motorised valve whose potentiometer follows the drives
`timescale 1ns/1ps
module vmoc_valve_model (
    input wire logic ref_clk,
    input wire logic drive_open,
    input wire logic drive_close,
    output logic [11:0] pos_fb
);
    // One step a clock; limit switches hold it at either end
    initial pos_fb = 12'h800;
    always @(posedge ref_clk) begin
        if (drive_open && pos_fb != 12'hfff) begin
            pos_fb <= pos_fb + 12'h001;
        end else if (drive_close && pos_fb != 12'h000) begin
            pos_fb <= pos_fb - 12'h001;
        end
    end
endmodule

// File: test_vmoc_core.sv
// Testbench: drive decisions, limiter, stop action and tuning start
`timescale 1ns/1ps
module test_vmoc_core;
    import vmoc_pkg::*;
    logic ref_clk, reset_n, pos_pid_selected, run_mode, motor_time_wr;
    logic fb_fitted, fb_break, break_action, sat_action, shift_key;
    logic any_key, prep_screen_req, drive_open, drive_close;
    logic at_prep_screen, at_monitor_screen, auto_startup_tune;
    logic [9:0] manipulated_output, motor_time_in, out_limit_low;
    logic [9:0] out_limit_high, motor_time, valve_position;
    logic signed [15:0] pid_delta;
    logic [6:0] neutral_zone;
    logic [5:0] diff_gap;
    logic [10:0] limiter_setting;
    logic [11:0] valve_position_feedback;
    logic [1:0] stop_action, auto_startup_tune_cond, cal_state;
    logic [15:0] target_setpoint;
    int mismatches, n_compared, c;
    // Short ms tick keeps the limiter run to a few dozen cycles
    vmoc_core #(.MS_CYCLES(4)) vmoc_core_inst (.ref_clk, .reset_n,
        .pos_pid_selected, .run_mode, .manipulated_output, .pid_delta,
        .neutral_zone, .diff_gap, .limiter_setting, .motor_time_in,
        .motor_time_wr, .fb_fitted, .fb_break, .valve_position_feedback,
        .break_action, .stop_action, .sat_action, .out_limit_low,
        .out_limit_high, .shift_key, .any_key, .prep_screen_req,
        .auto_startup_tune_cond, .target_setpoint, .drive_open,
        .drive_close, .motor_time, .cal_state, .at_prep_screen,
        .at_monitor_screen, .valve_position, .auto_startup_tune);
    vmoc_valve_model vmoc_valve_model_inst (.ref_clk, .drive_open,
        .drive_close, .pos_fb(valve_position_feedback));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Inputs move 1 ns after the edge so no race with the sampling edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    function automatic logic [9:0] drv();
        return {8'h00, drive_open, drive_close};
    endfunction
    task automatic chk(input string what, input logic [9:0] exp,
        input logic [9:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic st_count(output int n);
        n = 0;
        repeat (4) begin
            step(1);
            if (auto_startup_tune === 1'b1) n++;
        end
    endtask
    task automatic report_and_stop;
        $display("Counts: %0d compared, %0d mismatched", n_compared,
            mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    function automatic logic [9:0] scr();
        return {8'h00, at_prep_screen, at_monitor_screen};
    endfunction
    // Bounded wait for a calibration code, then judged like any result
    task automatic wait_cal(input logic [1:0] code, input int n);
        repeat (n) begin
            if (cal_state !== code) step(1);
        end
        chk("cal_state", {8'h00, code}, {8'h00, cal_state});
    endtask
    task automatic t_reset;
        chk("motor_time", MOTOR_DEF, motor_time);
        chk("cal_state", {8'h00, CAL_END}, {8'h00, cal_state});
        chk("drives", 10'h000, drv());
        st_count(c);
        chk("st power", 10'h001, 10'(c));
        $display("t_reset done");
    endtask
    // Open-loop deviation: zone, gap, reversal, method deselected
    task automatic t_open_loop;
        run_mode = 1'b1;
        pid_delta = 16'sd30;
        step(3);
        chk("open", 10'h002, drv());
        pid_delta = 16'sd15;
        step(3);
        chk("gap", 10'h002, drv());
        pid_delta = 16'sd5;
        step(3);
        chk("zone", 10'h000, drv());
        pid_delta = 16'sd30;
        step(3);
        pid_delta = -16'sd30;
        step(4);
        chk("reverse", 10'h001, drv());
        pos_pid_selected = 1'b0;
        step(3);
        chk("deselect", 10'h000, drv());
        pos_pid_selected = 1'b1;
        $display("t_open_loop done");
    endtask
    // Limit 0.1 % of 10 s is 10 ms, i.e. 40 cycles at this tick
    task automatic t_limiter;
        limiter_setting = 11'h001;
        pid_delta = 16'sd30;
        step(4);
        chk("lim on", 10'h002, drv());
        step(60);
        chk("lim off", 10'h000, drv());
        pid_delta = -16'sd30;
        step(6);
        chk("lim rev", 10'h001, drv());
        limiter_setting = LIM_OFF;
        step(60);
        chk("lim zero", 10'h001, drv());
        $display("t_limiter done");
    endtask
    // Code order matches {open, close}: 0 none, 1 close, 2 open
    task automatic t_stop;
        run_mode = 1'b0;
        for (int i = 0; i < 3; i++) begin
            stop_action = i[1:0];
            step(3);
            chk("stop", {8'h00, stop_action}, drv());
        end
        fb_fitted = 1'b1;
        fb_break = 1'b1;
        run_mode = 1'b1;
        step(3);
        chk("break", {8'h00, STOP_OPEN_ON}, drv());
        break_action = 1'b1;
        step(3);
        chk("continue", 10'h001, drv());
        {fb_fitted, fb_break, run_mode, break_action} = 4'h0;
        $display("t_stop done");
    endtask
    task automatic t_st;
        auto_startup_tune_cond = ST_TARGET_ONLY;
        target_setpoint = 16'h0100;
        st_count(c);
        chk("st target", 10'h001, 10'(c));
        auto_startup_tune_cond = ST_POWER_RUN;
        target_setpoint = 16'h0200;
        st_count(c);
        chk("st no target", 10'h000, 10'(c));
        run_mode = 1'b1;
        st_count(c);
        chk("st run", 10'h001, 10'(c));
        $display("t_st done");
    endtask
    // Time write, calibration run, then live feedback at the open end
    task automatic t_cal;
        {motor_time_in, motor_time_wr} = 11'h029;
        step(1);
        motor_time_in = 10'h003;
        step(1);
        {motor_time_wr, run_mode, fb_fitted, prep_screen_req} = 4'h3;
        chk("motor set", 10'h014, motor_time);
        step(1);
        {prep_screen_req, shift_key} = 2'h1;
        chk("screens", 10'h002, scr());
        step(19990);
        chk("cal early", 10'h000, {8'h00, cal_state});
        wait_cal(CAL_OPEN, 100);
        shift_key = 1'b0;
        step(2);
        chk("cal open", 10'h002, drv());
        wait_cal(CAL_CLOSE, 8000);
        wait_cal(CAL_END, 10000);
        chk("cal prep", 10'h002, scr());
        chk("cal time", 10'h014, motor_time);
        // Open limit below full scale so the drive reaches it unhindered
        {manipulated_output, out_limit_high} = {FULL_SCALE, 10'h384};
        {run_mode, sat_action, limiter_setting} = 13'h1801;
        step(200);
        chk("no limit", 10'h002, drv());
        step(4200);
        chk("sat keep", 10'h002, drv());
        chk("full open", FULL_SCALE, valve_position);
        sat_action = 1'b0;
        step(2);
        chk("sat stop", 10'h000, drv());
        $display("t_cal done");
    endtask
    initial begin
        {pos_pid_selected, run_mode, motor_time_wr, fb_fitted} = 4'h8;
        {fb_break, break_action, sat_action, shift_key} = 4'h0;
        {any_key, prep_screen_req, reset_n} = 3'h0;
        {manipulated_output, motor_time_in, out_limit_low} = 30'h0;
        out_limit_high = FULL_SCALE;
        pid_delta = 16'sd0;
        neutral_zone = NZ_DEF;
        diff_gap = GAP_DEF;
        limiter_setting = LIM_OFF;
        {stop_action, auto_startup_tune_cond} = 4'h0;
        target_setpoint = 16'h0000;
        step(3);
        reset_n = 1'b1;
        t_reset();
        t_open_loop();
        t_limiter();
        t_stop();
        t_st();
        t_cal();
        report_and_stop();
    end
    // Tests need about 160 us; this cuts a hang short
    initial begin
        #250000;
        mismatches++;
        report_and_stop();
    end
endmodule
